//--- design/pnsr_pkg.sv
// register map, field positions and reset values of the next-page and status summary bank
// assumes a 32-bit AHB-Lite slave with each register in one aligned word at byte address 4*index
package pnsr_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_AUTONEG_EXPANSION = 6'h06;
    localparam logic [5:0] IDX_NEXT_PAGE_TRANSMIT = 6'h07;
    localparam logic [5:0] IDX_PHY_STATUS_SUMMARY = 6'h10;
    localparam logic [5:0] IDX_FALSE_CARRIER_COUNT = 6'h14;
    localparam logic [5:0] IDX_RX_ERROR_COUNT = 6'h15;
    localparam logic [5:0] IDX_TENBASE_STATUS_CTRL = 6'h1a;
    localparam logic [5:0] IDX_INT_STATUS = 6'h1c;
    localparam logic [5:0] IDX_INT_MASK = 6'h1d;

    // next page transmit fields
    localparam int NPT_NEXT_PAGE_BIT = 15;
    localparam int NPT_MSG_PAGE_BIT = 13;
    localparam int NPT_WILL_COMPLY_ACK_BIT = 12;
    localparam int NPT_TOGGLE_BIT = 11;
    localparam int NPT_CODE_MSB = 10;
    localparam logic NPT_NEXT_PAGE_RST = 1'h0;
    localparam logic NPT_MSG_PAGE_RST = 1'h1;
    localparam logic NPT_WILL_COMPLY_ACK_RST = 1'h0;
    localparam logic NPT_TOGGLE_RST = 1'h0;
    localparam logic [10:0] NPT_CODE_RST = 11'h001;

    // status summary fields
    localparam int SUM_RX_ERR_BIT = 13;
    localparam int SUM_POLARITY_BIT = 12;
    localparam int SUM_FALSE_CARRIER_BIT = 11;
    localparam int SUM_SIGNAL_DETECT_BIT = 10;
    localparam int SUM_DESCR_LOCK_BIT = 9;
    localparam int SUM_PAGE_RX_BIT = 8;

    // other registers
    localparam int ANX_PAGE_RX_BIT = 1;
    localparam int TBS_POLARITY_BIT = 4;

    // interrupt status / mask layout
    localparam int INT_RX_ERR_BIT = 0;
    localparam int INT_FALSE_CARRIER_BIT = 1;
    localparam int INT_PAGE_RX_BIT = 2;
    localparam int INT_SIGNAL_LOST_BIT = 3;
    localparam int INT_LOCK_LOST_BIT = 4;
    localparam int INT_WIDTH = 5;
    localparam logic [4:0] INT_MASK_RST = 5'h00;

    typedef enum logic [1:0] {BS_IDLE, BS_WRITE, BS_READ, BS_RDONE} pnsr_bus_st_t;
endpackage : pnsr_pkg

//--- design/pnsr_regs.sv
// management register bank: next-page transmit fields including the code field, status summary upper half,
// the clear-on-read side registers that release its latches, and an interrupt block
// assumes phy event inputs come from logic on hclk and are one-cycle pulses or live levels
//
// Notes on behaviour
// - bit 12 read/write comply acknowledge, reset 0
// - bit 11 read-only, inverse of previous toggle
// - code field bits 10:0 read/write, reset 1
// - message flag bit 13 selects message page
// - summary bits 15:14 read zero, ignore writes
// - bit 13 latches receive error, cleared by 0x15
// - bit 12 mirrors polarity, cleared by that register
// - bit 11 latches false carrier, cleared by 0x14
// - bit 10 signal detect, latch low, reset 0
// - bit 9 descrambler lock, latch low, reset 0
// - bit 8 mirrors page received, cleared by 0x06
// - page received sets on word, clears on read
`timescale 1ns/1ps
module pnsr_regs
    import pnsr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // phy events and levels
    input wire logic rx_error_evt,
    input wire logic false_carrier_evt,
    input wire logic polarity_inverted,
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    input wire logic lcw_received,
    input wire logic lcw_exchanged,
    input wire logic lcw_prev_toggle,
    // next page fields towards the arbitration logic
    output logic np_next_page,
    output logic np_message_page,
    output logic np_will_comply_ack,
    output logic np_tx_toggle_bit,
    output logic [10:0] np_code,
    output logic np_is_message,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    pnsr_bus_st_t bus_st_r, bus_st_nxt;
    logic [5:0] addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic next_page_r, next_page_nxt;
    logic message_page_flag_r, message_page_flag_nxt;
    logic will_comply_ack_r, will_comply_ack_nxt;
    logic tx_toggle_bit_r, tx_toggle_bit_nxt;
    logic [10:0] code_r, code_nxt;
    logic rx_err_latch_r, rx_err_latch_nxt;
    logic false_carrier_latch_r, false_carrier_latch_nxt;
    logic polarity_latch_r, polarity_latch_nxt;
    logic page_rx_r, page_rx_nxt;
    logic sd_low_seen_r, sd_low_seen_nxt;
    logic lock_low_seen_r, lock_low_seen_nxt;
    logic [INT_WIDTH-1:0] int_sts_r, int_sts_nxt;
    logic [INT_WIDTH-1:0] int_mask_r, int_mask_nxt;
    logic irq_r, irq_nxt;

    logic accept;
    logic rd_strobe;
    logic wr_strobe;
    logic [15:0] npt_word;
    logic [15:0] sum_word;
    logic [INT_WIDTH-1:0] int_evt;
    logic sd_live_read;
    logic lock_live_read;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    // reads take one wait state so the word is sampled after any preceding write has landed
    assign accept = hsel && htrans[1] && hready;
    assign hreadyout = (bus_st_r != BS_READ);
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign rd_strobe = (bus_st_r == BS_READ);
    assign wr_strobe = (bus_st_r == BS_WRITE);

    // latch-low view: zero while a low was seen since the last summary read
    assign sd_live_read = signal_detect && !sd_low_seen_r;
    assign lock_live_read = descrambler_lock && !lock_low_seen_r;

    always_comb begin
        npt_word = 16'h0000;
        npt_word[NPT_NEXT_PAGE_BIT] = next_page_r;
        npt_word[NPT_MSG_PAGE_BIT] = message_page_flag_r;
        npt_word[NPT_WILL_COMPLY_ACK_BIT] = will_comply_ack_r;
        npt_word[NPT_TOGGLE_BIT] = tx_toggle_bit_r;
        npt_word[NPT_CODE_MSB:0] = code_r;
    end

    // bits 15:14 and the lower byte stay zero
    always_comb begin
        sum_word = 16'h0000;
        sum_word[SUM_RX_ERR_BIT] = rx_err_latch_r;
        sum_word[SUM_POLARITY_BIT] = polarity_latch_r;
        sum_word[SUM_FALSE_CARRIER_BIT] = false_carrier_latch_r;
        sum_word[SUM_SIGNAL_DETECT_BIT] = sd_live_read;
        sum_word[SUM_DESCR_LOCK_BIT] = lock_live_read;
        sum_word[SUM_PAGE_RX_BIT] = page_rx_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus state and read data
    always_comb begin
        bus_st_nxt = BS_IDLE;
        addr_nxt = addr_r;
        rdata_nxt = rdata_r;
        unique case (bus_st_r)
            BS_READ: begin
                // no new transfer is taken while the read wait state runs
                bus_st_nxt = BS_RDONE;
                rdata_nxt = 32'h0000_0000;
                unique case (addr_r)
                    IDX_NEXT_PAGE_TRANSMIT: rdata_nxt[15:0] = npt_word;
                    IDX_PHY_STATUS_SUMMARY: rdata_nxt[15:0] = sum_word;
                    IDX_AUTONEG_EXPANSION: rdata_nxt[ANX_PAGE_RX_BIT] = page_rx_r;
                    IDX_TENBASE_STATUS_CTRL: rdata_nxt[TBS_POLARITY_BIT] = polarity_latch_r;
                    IDX_INT_STATUS: rdata_nxt[INT_WIDTH-1:0] = int_sts_r;
                    IDX_INT_MASK: rdata_nxt[INT_WIDTH-1:0] = int_mask_r;
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
            BS_IDLE, BS_WRITE, BS_RDONE: begin
                if (accept) begin
                    addr_nxt = haddr[7:2];
                    bus_st_nxt = hwrite ? BS_WRITE : BS_READ;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next page transmit register
    always_comb begin
        next_page_nxt = next_page_r;
        message_page_flag_nxt = message_page_flag_r;
        will_comply_ack_nxt = will_comply_ack_r;
        code_nxt = code_r;
        tx_toggle_bit_nxt = tx_toggle_bit_r;
        if (wr_strobe && addr_r == IDX_NEXT_PAGE_TRANSMIT) begin
            next_page_nxt = hwdata[NPT_NEXT_PAGE_BIT];
            message_page_flag_nxt = hwdata[NPT_MSG_PAGE_BIT];
            will_comply_ack_nxt = hwdata[NPT_WILL_COMPLY_ACK_BIT];
            code_nxt = hwdata[NPT_CODE_MSB:0];
        end
        // toggle is owned by arbitration; software writes to it are dropped
        if (lcw_exchanged) begin
            tx_toggle_bit_nxt = !lcw_prev_toggle;
        end
    end

    assign np_next_page = next_page_r;
    assign np_message_page = message_page_flag_r;
    assign np_will_comply_ack = will_comply_ack_r;
    assign np_tx_toggle_bit = tx_toggle_bit_r;
    assign np_code = code_r;
    assign np_is_message = message_page_flag_r;

    ////////////////////////////////////////////////////////////////////////////
    // latched status
    always_comb begin
        logic rd_sum;
        logic rd_rxerr;
        logic rd_fc;
        logic rd_tbs;
        logic rd_anx;
        rd_sum = rd_strobe && addr_r == IDX_PHY_STATUS_SUMMARY;
        rd_rxerr = rd_strobe && addr_r == IDX_RX_ERROR_COUNT;
        rd_fc = rd_strobe && addr_r == IDX_FALSE_CARRIER_COUNT;
        rd_tbs = rd_strobe && addr_r == IDX_TENBASE_STATUS_CTRL;
        rd_anx = rd_strobe && addr_r == IDX_AUTONEG_EXPANSION;
        // the event term is or-ed last so a coincident clearing read never hides it
        rx_err_latch_nxt = (rx_err_latch_r && !rd_rxerr) || rx_error_evt;
        false_carrier_latch_nxt = (false_carrier_latch_r && !rd_fc) || false_carrier_evt;
        polarity_latch_nxt = (polarity_latch_r && !rd_tbs) || polarity_inverted;
        page_rx_nxt = (page_rx_r && !rd_anx) || lcw_received;
        // a summary read releases the hold; a still-low input re-captures at once
        sd_low_seen_nxt = (sd_low_seen_r && !rd_sum) || !signal_detect;
        lock_low_seen_nxt = (lock_low_seen_r && !rd_sum) || !descrambler_lock;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set wins
    always_comb begin
        int_evt = '0;
        int_evt[INT_RX_ERR_BIT] = rx_error_evt;
        int_evt[INT_FALSE_CARRIER_BIT] = false_carrier_evt;
        int_evt[INT_PAGE_RX_BIT] = lcw_received;
        int_evt[INT_SIGNAL_LOST_BIT] = !signal_detect && !sd_low_seen_r;
        int_evt[INT_LOCK_LOST_BIT] = !descrambler_lock && !lock_low_seen_r;
    end

    always_comb begin
        int_sts_nxt = int_sts_r;
        int_mask_nxt = int_mask_r;
        if (wr_strobe && addr_r == IDX_INT_STATUS) begin
            int_sts_nxt = int_sts_r & ~hwdata[INT_WIDTH-1:0];
        end
        if (wr_strobe && addr_r == IDX_INT_MASK) begin
            int_mask_nxt = hwdata[INT_WIDTH-1:0];
        end
        int_sts_nxt = int_sts_nxt | int_evt;
        irq_nxt = |(int_sts_nxt & int_mask_nxt);
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    // bus state and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r <= BS_IDLE;
            addr_r <= 6'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            bus_st_r <= bus_st_nxt;
            addr_r <= addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // next page transmit fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            next_page_r <= NPT_NEXT_PAGE_RST;
            message_page_flag_r <= NPT_MSG_PAGE_RST;
            will_comply_ack_r <= NPT_WILL_COMPLY_ACK_RST;
            tx_toggle_bit_r <= NPT_TOGGLE_RST;
            code_r <= NPT_CODE_RST;
        end else begin
            next_page_r <= next_page_nxt;
            message_page_flag_r <= message_page_flag_nxt;
            will_comply_ack_r <= will_comply_ack_nxt;
            tx_toggle_bit_r <= tx_toggle_bit_nxt;
            code_r <= code_nxt;
        end
    end

    // latch-high status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_err_latch_r <= 1'b0;
            false_carrier_latch_r <= 1'b0;
            polarity_latch_r <= 1'b0;
            page_rx_r <= 1'b0;
        end else begin
            rx_err_latch_r <= rx_err_latch_nxt;
            false_carrier_latch_r <= false_carrier_latch_nxt;
            polarity_latch_r <= polarity_latch_nxt;
            page_rx_r <= page_rx_nxt;
        end
    end

    // latch-low holds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // held low at reset so both latch-low bits read 0 until a summary read
            sd_low_seen_r <= 1'b1;
            lock_low_seen_r <= 1'b1;
        end else begin
            sd_low_seen_r <= sd_low_seen_nxt;
            lock_low_seen_r <= lock_low_seen_nxt;
        end
    end

    // interrupt status and mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_sts_r <= '0;
            int_mask_r <= INT_MASK_RST;
        end else begin
            int_sts_r <= int_sts_nxt;
            int_mask_r <= int_mask_nxt;
        end
    end

    // interrupt line, registered so decode hazards never reach the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

endmodule : pnsr_regs

//--- dv/pnsr_regs_asserts.sv
// checker for pnsr_regs: read wait state, next-page fields, latch-low reads
// sees only the top ports; hready is assumed tied to hreadyout
`timescale 1ns/1ps
module pnsr_regs_asserts
    import pnsr_pkg::*;
(
    // bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    // phy side
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    input wire logic lcw_exchanged,
    input wire logic lcw_prev_toggle,
    input wire logic np_next_page,
    input wire logic np_message_page,
    input wire logic np_will_comply_ack,
    input wire logic np_tx_toggle_bit,
    input wire logic [10:0] np_code,
    input wire logic np_is_message
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    logic sum_rd;
    assign take = hsel && htrans[1] && hready;
    assign sum_rd = take && !hwrite && haddr[7:2] == IDX_PHY_STATUS_SUMMARY;
    ////////////////////////////////////////
    property p_toggle; lcw_exchanged |=> np_tx_toggle_bit == !$past(lcw_prev_toggle); endproperty
    a_toggle: assert property (p_toggle) else $error("toggle not inverse of word");
    property p_toggle_hold; !lcw_exchanged |=> $stable(np_tx_toggle_bit); endproperty
    a_toggle_hold: assert property (p_toggle_hold) else $error("toggle moved");
    property p_msg; np_is_message == np_message_page; endproperty
    a_msg: assert property (p_msg) else $error("message page flag mismatch");
    property p_rst; $rose(hresetn) |-> np_code == NPT_CODE_RST && np_message_page && !np_will_comply_ack
        && !np_next_page && !np_tx_toggle_bit; endproperty
    a_rst: assert property (p_rst) else $error("next page reset value");
    property p_wr; take && hwrite && haddr[7:2] == IDX_NEXT_PAGE_TRANSMIT ##1 1'b1
        |=> np_code == $past(hwdata[NPT_CODE_MSB:0]) && np_will_comply_ack == $past(hwdata[NPT_WILL_COMPLY_ACK_BIT])
        && np_next_page == $past(hwdata[NPT_NEXT_PAGE_BIT]) && np_is_message == $past(hwdata[NPT_MSG_PAGE_BIT]);
    endproperty
    a_wr: assert property (p_wr) else $error("next page write lost");
    property p_sum; sum_rd |=> !hreadyout ##1 (hreadyout && hrdata[15:14] == 2'h0 && hrdata[7:0] == 8'h00); endproperty
    a_sum: assert property (p_sum) else $error("summary read shape");
    property p_sd_low; sum_rd && !signal_detect |=> ##1 !hrdata[10]; endproperty
    a_sd_low: assert property (p_sd_low) else $error("signal detect low missed");
    property p_lock_low; sum_rd && !descrambler_lock |=> ##1 !hrdata[9]; endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock low missed");
endmodule : pnsr_regs_asserts

bind pnsr_regs pnsr_regs_asserts pnsr_regs_asserts_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .signal_detect(signal_detect), .descrambler_lock(descrambler_lock),
    .lcw_exchanged(lcw_exchanged), .lcw_prev_toggle(lcw_prev_toggle), .np_next_page(np_next_page),
    .np_message_page(np_message_page),
    .np_will_comply_ack(np_will_comply_ack), .np_tx_toggle_bit(np_tx_toggle_bit), .np_code(np_code),
    .np_is_message(np_is_message));

//--- dv/pnsr_phy_model.sv
// phy-side source of event pulses and live levels, on hclk
// assumes the bench calls fire and lvl; the toggle line is noise outside an exchange
`timescale 1ns/1ps
module pnsr_phy_model (
    // clock
    input wire logic hclk,
    // events and levels
    output logic rx_error_evt,
    output logic false_carrier_evt,
    output logic polarity_inverted,
    output logic signal_detect,
    output logic descrambler_lock,
    output logic lcw_received,
    output logic lcw_exchanged,
    output logic lcw_prev_toggle
);
    logic [4:0] ev = 5'h00;
    logic [1:0] lv = 2'h3;
    logic tgl = 1'b0;
    logic noise = 1'b0;
    assign {lcw_exchanged, lcw_received, polarity_inverted, false_carrier_evt, rx_error_evt} = ev;
    assign {signal_detect, descrambler_lock} = lv;
    // toggle value only means something while an exchange is flagged
    assign lcw_prev_toggle = ev[4] ? tgl : noise;
    always @(posedge hclk) noise <= ~noise;
    task automatic fire(input logic [4:0] m, input logic t);
        @(posedge hclk);
        ev <= m;
        tgl <= t;
        @(posedge hclk);
        ev <= 5'h00;
    endtask : fire
    task automatic lvl(input logic [1:0] v);
        @(posedge hclk);
        lv <= v;
    endtask : lvl
endmodule : pnsr_phy_model

//--- dv/pnsr_regs_tb_top.sv
// self-checking bench for pnsr_regs over ahb-lite, reads scored from a queue
// assumes one slave, so hready is hreadyout
`timescale 1ns/1ps
module pnsr_regs_tb_top
    import pnsr_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, seed = 32'h8b1027ad;
    logic hready, hreadyout, hresp, irq, rx_e, fc_e, pol, sd, lk, lcw_r, lcw_x, lcw_t;
    logic rd_ph = 1'b0;
    logic [63:0] e, expq[$];
    int mismatches = 0, n_compared = 0, cyc = 0, i;
    logic [4:0] ev [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
    logic [15:0] sb [4] = '{16'h2000, 16'h0800, 16'h1000, 16'h0100};
    logic [5:0] ci [4] = '{IDX_RX_ERROR_COUNT, IDX_FALSE_CARRIER_COUNT, IDX_TENBASE_STATUS_CTRL, IDX_AUTONEG_EXPANSION};
    logic [15:0] cv [4] = '{16'h0, 16'h0, 16'h0010, 16'h0002};
    assign hready = hreadyout;
    always #25 hclk = ~hclk;
    pnsr_regs pnsr_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_error_evt(rx_e), .false_carrier_evt(fc_e), .polarity_inverted(pol), .signal_detect(sd),
        .descrambler_lock(lk), .lcw_received(lcw_r), .lcw_exchanged(lcw_x), .lcw_prev_toggle(lcw_t),
        .np_next_page(), .np_message_page(), .np_will_comply_ack(), .np_tx_toggle_bit(), .np_code(),
        .np_is_message(), .irq(irq));
    pnsr_phy_model pnsr_phy_model_inst (.hclk(hclk), .rx_error_evt(rx_e), .false_carrier_evt(fc_e),
        .polarity_inverted(pol), .signal_detect(sd), .descrambler_lock(lk), .lcw_received(lcw_r),
        .lcw_exchanged(lcw_x), .lcw_prev_toggle(lcw_t));
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        n_compared++;
        if (g !== ex) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : bus
    task automatic rd(input logic [5:0] idx, input logic [15:0] ex, input logic [15:0] m);
        expq.push_back({16'h0, ex, 16'hffff, m});
        bus(1'b0, idx, 32'h0);
    endtask : rd
    task automatic irqc(input logic ex);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, ex}, {31'h0, irq});
    endtask : irqc
    // read data is scored at the edge that ends its data phase; a 20000 cycle ceiling cuts hangs
    always @(posedge hclk) begin
        if (rd_ph && hready) begin
            e = expq.pop_front();
            chk("hrdata", e[63:32] & e[31:0], hrdata & e[31:0]);
            chk("hresp", 32'h0, {31'h0, hresp});
        end
        if (hready) rd_ph <= hsel && htrans[1] && !hwrite;
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_NEXT_PAGE_TRANSMIT, 16'h2001, 16'hffff);
        rd(IDX_PHY_STATUS_SUMMARY, 16'h0000, 16'hffff);
        bus(1'b1, IDX_PHY_STATUS_SUMMARY, 32'hffffffff);
        rd(IDX_PHY_STATUS_SUMMARY, 16'h0600, 16'hffff);
        rd(6'h3f, 16'h0000, 16'hffff);
        for (i = 0; i < 4; i++) begin
            d = xs();
            bus(1'b1, IDX_NEXT_PAGE_TRANSMIT, d);
            rd(IDX_NEXT_PAGE_TRANSMIT, d[15:0] & 16'hb7ff, 16'hffff);
        end
        for (i = 0; i < 2; i++) begin
            d = xs();
            pnsr_phy_model_inst.fire(5'h10, d[0]);
            rd(IDX_NEXT_PAGE_TRANSMIT, {4'h0, ~d[0], 11'h0}, 16'h0800);
        end
        for (i = 0; i < 4; i++) begin
            pnsr_phy_model_inst.fire(ev[i], 1'b0);
            rd(IDX_PHY_STATUS_SUMMARY, sb[i], sb[i] | 16'hc000);
            rd(IDX_PHY_STATUS_SUMMARY, sb[i], sb[i]);
            rd(ci[i], cv[i], 16'hffff);
            rd(IDX_PHY_STATUS_SUMMARY, 16'h0, sb[i]);
            fork
                rd(ci[i], 16'h0, 16'hffff);
                begin
                    @(posedge hclk);
                    pnsr_phy_model_inst.fire(ev[i], 1'b0);
                end
            join
            rd(IDX_PHY_STATUS_SUMMARY, sb[i], sb[i]);
        end
        pnsr_phy_model_inst.lvl(2'h0);
        rd(IDX_PHY_STATUS_SUMMARY, 16'h0, 16'h0600);
        pnsr_phy_model_inst.lvl(2'h3);
        rd(IDX_PHY_STATUS_SUMMARY, 16'h0, 16'h0600);
        rd(IDX_PHY_STATUS_SUMMARY, 16'h0600, 16'h0600);
        irqc(1'b0);
        bus(1'b1, IDX_INT_MASK, 32'h1f);
        irqc(1'b1);
        rd(IDX_INT_STATUS, 16'h001f, 16'hffff);
        rd(IDX_INT_MASK, 16'h001f, 16'hffff);
        bus(1'b1, IDX_INT_STATUS, 32'h1f);
        irqc(1'b0);
        rd(IDX_INT_STATUS, 16'h0000, 16'hffff);
        pnsr_phy_model_inst.fire(5'h01, 1'b0);
        irqc(1'b1);
        bus(1'b1, IDX_INT_MASK, 32'h0);
        irqc(1'b0);
        give_verdict();
    end
endmodule : pnsr_regs_tb_top
